// >>> src/adsd_regs.vh
`ifndef ADSD_REGS_VH
`define ADSD_REGS_VH

// ****************************************************************
// instruction words of this group
// ****************************************************************
`define ADSD_OP_RD_RESULT_PAIR  10'h279
`define ADSD_OP_RD_RESULT_LOW   10'h249
`define ADSD_OP_WR_COMPARE_REF  10'h239
`define ADSD_OP_RD_CONV_CTRL    10'h244
`define ADSD_OP_WR_CONV_CTRL    10'h204
`define ADSD_OP_START_CONV      10'h29F
`define ADSD_OP_TEST_CONV_DONE  10'h287
`define ADSD_OP_NOP             10'h000
`define ADSD_OP_POWER_DOWN      10'h008
`define ADSD_OP_POWER_DOWN_ARM  10'h05B
`define ADSD_OP_POWER_FLAG_TEST 10'h003
`define ADSD_OP_WDOG_STOP_ARM   10'h29C
`define ADSD_OP_WDOG_RESTART    10'h2A0
`define ADSD_OP_CERAMIC_SELECT  10'h29A
`define ADSD_OP_RC_SELECT       10'h29B
`define ADSD_OP_RD_CLOCK_CTRL   10'h252
`define ADSD_OP_WR_CLOCK_CTRL   10'h216

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define ADSD_MODE_BIT           3
`define ADSD_RES_PAIR_HI_MSB    9
`define ADSD_RES_PAIR_HI_LSB    6
`define ADSD_RES_PAIR_LO_MSB    5
`define ADSD_RES_PAIR_LO_LSB    2
`define ADSD_RES_LOW_MSB        1
`define ADSD_RES_LOW_LSB        0
`define ADSD_REF_HI_MSB         7
`define ADSD_REF_HI_LSB         4
`define ADSD_REF_LO_MSB         3
`define ADSD_REF_LO_LSB         0
`define ADSD_NIB_RST            4'h0
`define ADSD_REF_RST            8'h00
`define ADSD_LOW_PAD            2'h0

`endif

// >>> src/adsd_instr_decode.v
`include "adsd_regs.vh"

module adsd_instr_decode #(
    parameter RES_W = 10,
    parameter MR_W  = 4
) (
    // clock and reset
    input  wire               sys_clk,
    input  wire               rst_n,
    // instruction from the core
    input  wire               instr_valid,
    input  wire [9:0]         instr_word,
    input  wire [3:0]         acc_in,
    input  wire [3:0]         breg_in,
    // status from neighbouring blocks
    input  wire [RES_W-1:0]   conv_result,
    input  wire               conv_done_set,
    input  wire               watchdog_flag_set,
    input  wire               power_flag,
    input  wire               converter_irq_select_bit,
    // write-back to the core
    output reg                acc_wr_q,
    output reg  [3:0]         acc_data_q,
    output reg                breg_wr_q,
    output reg  [3:0]         breg_data_q,
    output reg                pc_adv_q,
    output reg                skip_next_q,
    // converter side
    output reg  [3:0]         converter_control_reg_q,
    output reg  [7:0]         compare_ref_q,
    output reg                conv_start_q,
    output reg                cmp_start_q,
    output reg                conversion_done_flag_q,
    // system side
    output reg                watchdog_flag_q,
    output reg                watchdog_stopped_q,
    output reg                ram_backup_q,
    output reg                osc_rc_sel_q,
    output reg                onchip_osc_stop_q,
    output reg  [MR_W-1:0]    clock_control_reg_q
);

    // ****************************************************************
    // decode
    // ****************************************************************
    wire op_pair   = instr_valid && (instr_word == `ADSD_OP_RD_RESULT_PAIR);
    wire op_low    = instr_valid && (instr_word == `ADSD_OP_RD_RESULT_LOW);
    wire op_wref   = instr_valid && (instr_word == `ADSD_OP_WR_COMPARE_REF);
    wire op_rq     = instr_valid && (instr_word == `ADSD_OP_RD_CONV_CTRL);
    wire op_wq     = instr_valid && (instr_word == `ADSD_OP_WR_CONV_CTRL);
    wire op_start  = instr_valid && (instr_word == `ADSD_OP_START_CONV);
    wire op_tdone  = instr_valid && (instr_word == `ADSD_OP_TEST_CONV_DONE);
    wire op_nop    = instr_valid && (instr_word == `ADSD_OP_NOP);
    wire op_pdown  = instr_valid && (instr_word == `ADSD_OP_POWER_DOWN);
    wire op_parm   = instr_valid && (instr_word == `ADSD_OP_POWER_DOWN_ARM);
    wire op_pflag  = instr_valid && (instr_word == `ADSD_OP_POWER_FLAG_TEST);
    wire op_warm   = instr_valid && (instr_word == `ADSD_OP_WDOG_STOP_ARM);
    wire op_watchdog_restart_instr   = instr_valid && (instr_word == `ADSD_OP_WDOG_RESTART);
    wire op_cer    = instr_valid && (instr_word == `ADSD_OP_CERAMIC_SELECT);
    wire op_rc     = instr_valid && (instr_word == `ADSD_OP_RC_SELECT);
    wire op_rmr    = instr_valid && (instr_word == `ADSD_OP_RD_CLOCK_CTRL);
    wire op_wmr    = instr_valid && (instr_word == `ADSD_OP_WR_CLOCK_CTRL);

    wire any_op = op_pair | op_low | op_wref | op_rq | op_wq | op_start | op_tdone |
                  op_nop | op_pdown | op_parm | op_pflag | op_warm | op_watchdog_restart_instr |
                  op_cer | op_rc | op_rmr | op_wmr;

    wire cmp_mode = converter_control_reg_q[`ADSD_MODE_BIT];

    // arm states last exactly one executed instruction
    reg pd_arm_q;
    reg wd_arm_q;

    // ****************************************************************
    // write-back values
    // ****************************************************************
    reg        acc_wr_d;
    reg [3:0]  acc_data_d;
    reg        breg_wr_d;
    reg [3:0]  breg_data_d;
    reg        skip_d;
    reg        pc_adv_d;
    reg        conv_start_d;
    reg        cmp_start_d;
    reg        ram_backup_d;
    reg        done_flag_d;
    reg        wdog_flag_d;

    // skips use the flags as they stand before the executing edge
    wire done_skip  = op_tdone && !converter_irq_select_bit && conversion_done_flag_q;
    wire wd_skip    = op_watchdog_restart_instr && watchdog_flag_q;
    wire pflag_skip = op_pflag && power_flag;

    always @* begin
        acc_wr_d    = 1'h0;
        acc_data_d  = `ADSD_NIB_RST;
        breg_wr_d   = 1'h0;
        breg_data_d = `ADSD_NIB_RST;
        skip_d      = done_skip | wd_skip | pflag_skip;
        if (op_pair) begin
            acc_wr_d  = 1'h1;
            breg_wr_d = 1'h1;
            if (cmp_mode) begin
                breg_data_d = compare_ref_q[`ADSD_REF_HI_MSB:`ADSD_REF_HI_LSB];
                acc_data_d  = compare_ref_q[`ADSD_REF_LO_MSB:`ADSD_REF_LO_LSB];
            end else begin
                breg_data_d = conv_result[`ADSD_RES_PAIR_HI_MSB:`ADSD_RES_PAIR_HI_LSB];
                acc_data_d  = conv_result[`ADSD_RES_PAIR_LO_MSB:`ADSD_RES_PAIR_LO_LSB];
            end
        end else if (op_low) begin
            acc_wr_d   = 1'h1;
            acc_data_d = {conv_result[`ADSD_RES_LOW_MSB:`ADSD_RES_LOW_LSB],
                          `ADSD_LOW_PAD};
        end else if (op_rq) begin
            acc_wr_d   = 1'h1;
            acc_data_d = converter_control_reg_q;
        end else if (op_rmr) begin
            acc_wr_d   = 1'h1;
            acc_data_d = clock_control_reg_q[3:0];
        end
    end

    // ****************************************************************
    // strobes and flag next values
    // ****************************************************************
    always @* begin
        // every instruction of the group, nop and disabled writes included
        pc_adv_d     = any_op;
        conv_start_d = op_start && !cmp_mode;
        cmp_start_d  = op_start && cmp_mode;
        ram_backup_d = op_pdown && pd_arm_q;
        // a completion arriving with the clear wins
        done_flag_d = conversion_done_flag_q;
        if (conv_done_set) begin
            done_flag_d = 1'h1;
        end else if (op_start || done_skip) begin
            done_flag_d = 1'h0;
        end
        // likewise a watchdog event beats the restart clear
        wdog_flag_d = watchdog_flag_q;
        if (watchdog_flag_set) begin
            wdog_flag_d = 1'h1;
        end else if (wd_skip) begin
            wdog_flag_d = 1'h0;
        end
    end

    // ****************************************************************
    // write-back registers
    // ****************************************************************
    // data is zero whenever its write strobe is low
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_wr_q    <= 1'h0;
            acc_data_q  <= `ADSD_NIB_RST;
            breg_wr_q   <= 1'h0;
            breg_data_q <= `ADSD_NIB_RST;
            skip_next_q <= 1'h0;
        end else begin
            acc_wr_q    <= acc_wr_d;
            acc_data_q  <= acc_data_d;
            breg_wr_q   <= breg_wr_d;
            breg_data_q <= breg_data_d;
            skip_next_q <= skip_d;
        end
    end

    // ****************************************************************
    // one-cycle strobes
    // ****************************************************************
    // pulses stand for exactly one cycle after the executing edge
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_adv_q     <= 1'h0;
            conv_start_q <= 1'h0;
            cmp_start_q  <= 1'h0;
            ram_backup_q <= 1'h0;
        end else begin
            pc_adv_q     <= pc_adv_d;
            conv_start_q <= conv_start_d;
            cmp_start_q  <= cmp_start_d;
            ram_backup_q <= ram_backup_d;
        end
    end

    // ****************************************************************
    // converter control register
    // ****************************************************************
    // its mode bit steers the pair read, the reference write and the start; the low read, control read and done test ignore it
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_control_reg_q <= `ADSD_NIB_RST;
        end else if (op_wq) begin
            converter_control_reg_q <= acc_in;
        end
    end

    // ****************************************************************
    // comparator reference
    // ****************************************************************
    // dropped in conversion mode, so a mode switch finds the old reference
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_ref_q <= `ADSD_REF_RST;
        end else if (op_wref && cmp_mode) begin
            compare_ref_q <= {breg_in, acc_in};
        end
    end

    // ****************************************************************
    // conversion done flag
    // ****************************************************************
    // set and clear are resolved in the next-value logic above
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_done_flag_q <= 1'h0;
        end else begin
            conversion_done_flag_q <= done_flag_d;
        end
    end

    // ****************************************************************
    // watchdog flag
    // ****************************************************************
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_flag_q <= 1'h0;
        end else begin
            watchdog_flag_q <= wdog_flag_d;
        end
    end

    // ****************************************************************
    // watchdog stop
    // ****************************************************************
    // sticky: only a reset lets the watchdog run again
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_stopped_q <= 1'h0;
        end else if (op_watchdog_restart_instr && wd_arm_q) begin
            watchdog_stopped_q <= 1'h1;
        end
    end

    // ****************************************************************
    // oscillator selection
    // ****************************************************************
    // the stop is sticky: this block never restarts the on-chip oscillator
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_rc_sel_q      <= 1'h0;
            onchip_osc_stop_q <= 1'h0;
        end else if (op_cer || op_rc) begin
            osc_rc_sel_q      <= op_rc;
            onchip_osc_stop_q <= 1'h1;
        end
    end

    // ****************************************************************
    // clock control register
    // ****************************************************************
    // only the low MR_W accumulator bits are kept
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_control_reg_q <= {MR_W{1'h0}};
        end else if (op_wmr) begin
            clock_control_reg_q <= acc_in[MR_W-1:0];
        end
    end

    // ****************************************************************
    // arm states
    // ****************************************************************
    // any other executed instruction disarms; idle cycles keep the arm
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_arm_q <= 1'h0;
            wd_arm_q <= 1'h0;
        end else if (instr_valid) begin
            pd_arm_q <= op_parm;
            wd_arm_q <= op_warm;
        end
    end

endmodule // adsd_instr_decode

// >>> tb/adsd_instr_decode_asserts.sv
module adsd_instr_decode_asserts #(parameter RES_W = 10) (
    // core side
    input logic             sys_clk, rst_n, instr_valid, power_flag,
    input logic [9:0]       instr_word,
    input logic [RES_W-1:0] conv_result,
    input logic             conv_done_set, converter_irq_select_bit,
    input logic [3:0]       acc_in, breg_in,
    // results
    input logic [3:0]       acc_data_q, breg_data_q, converter_control_reg_q,
    input logic [7:0]       compare_ref_q,
    input logic             acc_wr_q, pc_adv_q, skip_next_q, conv_start_q, cmp_start_q,
    input logic             conversion_done_flag_q, ram_backup_q, watchdog_stopped_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // unused code point stands in for idle cycles
    wire [9:0] op = instr_valid ? instr_word : 10'h3FF;
    wire       m = converter_control_reg_q[3];
    sequence s_pd; op == 10'h05B ##1 op == 10'h008; endsequence
    sequence s_wd; op == 10'h29C ##1 op == 10'h2A0; endsequence
    chk_pair_conv:
        assert property (op == 10'h279 && !m |=> breg_data_q == $past(conv_result[9:6])
            && acc_data_q == $past(conv_result[5:2])) else $error("pair read wrong");
    chk_low_read:
        assert property (op == 10'h249 |=> acc_wr_q && acc_data_q == {$past(conv_result[1:0]),
            2'h0}) else $error("low read wrong");
    chk_ref_ignore:
        assert property (op == 10'h239 && !m |=> pc_adv_q && !acc_wr_q && $stable(compare_ref_q))
            else $error("ref write not ignored");
    chk_start_mode:
        assert property (op == 10'h29F |=> conv_start_q == !$past(m) && cmp_start_q == $past(m)
            && conversion_done_flag_q == $past(conv_done_set)) else $error("start wrong");
    chk_done_skip:
        assert property (op == 10'h287 && !converter_irq_select_bit |=>
            skip_next_q == $past(conversion_done_flag_q)) else $error("done skip wrong");
    chk_nop_quiet:
        assert property (op == 10'h000 |=> pc_adv_q && !skip_next_q && !acc_wr_q
            && $stable(compare_ref_q)) else $error("nop not quiet");
    chk_backup_arm:
        assert property (s_pd |=> ram_backup_q) else $error("no back-up");
    chk_wdog_stop:
        assert property (s_wd |=> watchdog_stopped_q) else $error("watchdog not stopped");
    chk_pflag_skip:
        assert property (op == 10'h003 |=> skip_next_q == $past(power_flag))
            else $error("power flag skip wrong");
    chk_pair_ref:
        assert property (op == 10'h279 && m |=> breg_data_q == $past(compare_ref_q[7:4])
            && acc_data_q == $past(compare_ref_q[3:0])) else $error("pair ref read wrong");
    chk_ref_write:
        assert property (op == 10'h239 && m |=> compare_ref_q == {$past(breg_in), $past(acc_in)})
            else $error("ref write wrong");
    chk_ctrl_write:
        assert property (op == 10'h204 |=> converter_control_reg_q == $past(acc_in))
            else $error("ctrl write wrong");
endmodule // adsd_instr_decode_asserts

bind adsd_instr_decode adsd_instr_decode_asserts #(.RES_W(RES_W)) adsd_chk_inst (.*);

// >>> tb/adsd_conv_model.sv
module adsd_conv_model #(parameter DLY = 6, parameter [9:0] RES = 10'h2D5) (
    input  wire       sys_clk, rst_n, conv_start_q, cmp_start_q,
    output logic [9:0] conv_result,
    output logic       conv_done_set
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt;
    // result shows the inverse until a conversion lands, so stale reads are caught
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            conv_done_set <= 1'h0;
            conv_result <= ~RES;
        end else begin
            conv_done_set <= (cnt == 1);
            if (conv_start_q || cmp_start_q)
                cnt <= DLY;
            else if (cnt != 0)
                cnt <= cnt - 1;
            if (cnt == 1)
                conv_result <= RES;
        end
    end
endmodule // adsd_conv_model

// >>> tb/adsd_instr_decode_bench.sv
module adsd_instr_decode_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic       sys_clk = '0, rst_n = '0, instr_valid = '0, power_flag = '0;
    logic       watchdog_flag_set = '0, converter_irq_select_bit = '0;
    logic [9:0] instr_word = '0;
    logic [3:0] acc_in = '0, breg_in = '0;
    wire  [9:0] conv_result;
    wire  [7:0] compare_ref_q;
    wire  [3:0] acc_data_q, breg_data_q, converter_control_reg_q, clock_control_reg_q;
    wire        conv_done_set, acc_wr_q, breg_wr_q, pc_adv_q, skip_next_q, conv_start_q;
    wire        cmp_start_q, conversion_done_flag_q, watchdog_flag_q, watchdog_stopped_q;
    wire        ram_backup_q, osc_rc_sel_q, onchip_osc_stop_q;
    int         failures = 0, n_checks = 0, cyc = 0;
    adsd_instr_decode adsd_instr_decode_inst (.*);
    adsd_conv_model adsd_conv_model_inst (.*);
    always #2.5 sys_clk = ~sys_clk;
    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            test_done();
        end
    end
    // valid stays up after ex so back-to-back words need no idle cycle
    task automatic ex(input logic [9:0] w, input logic [3:0] a = '0, b = '0);
        instr_valid = 1'h1;
        instr_word = w;
        acc_in = a;
        breg_in = b;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic tick();
        instr_valid = 1'h0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic ck(input string nm, input logic [9:0] e, g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        rst_n = 1'h1;
        ck("ref rst", 8'h00, compare_ref_q);
        ex(10'h204, 4'h5);
        ck("ctrl wr", 4'h5, converter_control_reg_q);
        ex(10'h244);
        ck("ctrl rd", 4'h5, acc_data_q);
        ck("ctrl kept", 4'h5, converter_control_reg_q);
        ex(10'h29F);
        ck("conv start", 1'h1, conv_start_q);
        ck("cmp idle", 1'h0, cmp_start_q);
        for (int i = 0; i < 20 && conversion_done_flag_q !== 1'h1; i++)
            tick();
        ex(10'h279);
        ck("pair b", 4'hB, breg_data_q);
        ck("pair a", 4'h5, acc_data_q);
        ck("pair bwr", 1'h1, breg_wr_q);
        ex(10'h249);
        ck("low a", 4'h4, acc_data_q);
        ck("low awr", 1'h1, acc_wr_q);
        ck("low bwr", 1'h0, breg_wr_q);
        ex(10'h239, 4'h3, 4'hC);
        ck("ref kept", 8'h00, compare_ref_q);
        ck("ref pc", 1'h1, pc_adv_q);
        converter_irq_select_bit = 1'h1;
        ex(10'h287);
        ck("sel1 skip", 1'h0, skip_next_q);
        ck("sel1 flag", 1'h1, conversion_done_flag_q);
        converter_irq_select_bit = 1'h0;
        ex(10'h287);
        ck("sel0 skip", 1'h1, skip_next_q);
        ck("sel0 flag", 1'h0, conversion_done_flag_q);
        $display("test conversion done");
        ex(10'h204, 4'h8);
        ex(10'h239, 4'h3, 4'hC);
        ck("ref wr", 8'hC3, compare_ref_q);
        ex(10'h279);
        ck("ref b", 4'hC, breg_data_q);
        ck("ref a", 4'h3, acc_data_q);
        ex(10'h29F);
        ck("cmp start", 1'h1, cmp_start_q);
        ck("cmp conv", 1'h0, conv_start_q);
        $display("test comparator done");
        ex(10'h000);
        ck("nop pc", 1'h1, pc_adv_q);
        ck("nop acc", 1'h0, acc_wr_q);
        ex(10'h008);
        ck("unarmed", 1'h0, ram_backup_q);
        ex(10'h05B);
        ex(10'h008);
        ck("backup", 1'h1, ram_backup_q);
        for (int p = 0; p < 2; p++) begin
            power_flag = p[0];
            ex(10'h003);
            ck("pflag skip", p[0], skip_next_q);
        end
        tick();
        watchdog_flag_set = 1'h1;
        tick();
        watchdog_flag_set = 1'h0;
        ck("wdf set", 1'h1, watchdog_flag_q);
        ex(10'h2A0);
        ck("wdf skip", 1'h1, skip_next_q);
        ck("wdf clear", 1'h0, watchdog_flag_q);
        ck("wd running", 1'h0, watchdog_stopped_q);
        ex(10'h29C);
        ex(10'h2A0);
        ck("wd stopped", 1'h1, watchdog_stopped_q);
        ex(10'h29B);
        ck("rc sel", 1'h1, osc_rc_sel_q);
        ck("osc stop", 1'h1, onchip_osc_stop_q);
        ex(10'h29A);
        ck("ceramic", 1'h0, osc_rc_sel_q);
        ex(10'h216, 4'hA);
        ex(10'h252);
        ck("mr rd", 4'hA, acc_data_q);
        ck("mr reg", 4'hA, clock_control_reg_q);
        $display("test system done");
        tick();
        test_done();
    end
endmodule // adsd_instr_decode_bench
